// file: hdl/port_e_pkg.sv
package port_e_pkg;
    localparam int NPINS = 3;
    localparam logic [2:0] ADDR_PIN_LEVELS = 3'h0;
    localparam logic [2:0] ADDR_LATCH = 3'h1;
    localparam logic [2:0] ADDR_DIR = 3'h2;
    localparam logic [2:0] ADDR_ANALOG = 3'h3;
    localparam logic [2:0] ADDR_PADCFG = 3'h4;
    localparam int DIR_PORT_D_PU_BIT = 7;
    localparam int DIR_PORT_E_PU_BIT = 6;
    localparam int ANALOG_FIRST_BIT = 5;
    localparam int PADCFG_TTL_BIT = 0;
    localparam logic [7:0] DIR_RESET = 8'h07;
    localparam logic [7:0] ANALOG_RESET = 8'hff;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] PADCFG_RESET = 8'h00;
    localparam logic [7:0] DIR_WMASK = 8'hc7;
endpackage

// file: hdl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// file: hdl/input_buffer_sel.sv
`timescale 1ns/1ps
`default_nettype none
module input_buffer_sel #(
    parameter int WIDTH = 3
) (
    input wire logic ttl_select,
    input wire logic [WIDTH-1:0] schmitt_level,
    input wire logic [WIDTH-1:0] ttl_level,
    output logic [WIDTH-1:0] buffered
);
    // Threshold choice is a pad feature; here it picks which comparator feeds the core
    assign buffered = ttl_select ? ttl_level : schmitt_level;
endmodule
`default_nettype wire

// file: hdl/port_e_pin_control.sv
`timescale 1ns/1ps
`default_nettype none
module port_e_pin_control
    import port_e_pkg::*;
#(
    parameter int PINS = port_e_pkg::NPINS
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [2:0] pin_schmitt_in,
    input wire logic [2:0] pin_ttl_in,
    output logic [2:0] pin_out,
    output logic [2:0] pin_oe,
    output logic [2:0] pin_pullup_en,
    output logic [2:0] pin_analog_sel,
    input wire logic host_port_enable,
    input wire logic host_port_read_strobe,
    input wire logic host_port_write_strobe,
    input wire logic host_port_byte_enable,
    output logic host_port_read_strobe_in,
    output logic host_port_write_strobe_in,
    output logic port_d_pullup_enable,
    output logic host_port_ttl_select
);
    import port_e_pkg::*;

    initial begin
        if (PINS != NPINS) begin
            $error("port_e_pin_control serves exactly three pins");
        end
    end

    logic [7:0] latch_q;
    logic [7:0] dir_q;
    logic [7:0] analog_q;
    logic [7:0] padcfg_q;
    logic [5:0] pad_sync;
    logic [2:0] level_sync;
    logic [2:0] digital_level;
    logic [2:0] pin_dir;
    logic [2:0] analog_sel;
    logic [2:0] host_drive;
    logic port_e_pullup_enable;

    assign pin_dir = dir_q[2:0];
    assign analog_sel = analog_q[ANALOG_FIRST_BIT +: 3];
    assign port_e_pullup_enable = dir_q[DIR_PORT_E_PU_BIT];
    assign port_d_pullup_enable = dir_q[DIR_PORT_D_PU_BIT];
    assign host_port_ttl_select = padcfg_q[PADCFG_TTL_BIT];
    assign pin_analog_sel = analog_sel;

    // Both comparators are synchronised before the choice, so a select change never meets a raw pad
    pin_sync #(
        .WIDTH(6)
    ) u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .async_in({pin_ttl_in, pin_schmitt_in}),
        .sync_out(pad_sync)
    );

    input_buffer_sel #(
        .WIDTH(3)
    ) u_buf (
        .ttl_select(host_port_enable & host_port_ttl_select),
        .schmitt_level(pad_sync[2:0]),
        .ttl_level(pad_sync[5:3]),
        .buffered(level_sync)
    );

    // Analog pins read zero so a floating analog node never toggles logic
    assign digital_level = level_sync & ~analog_sel;

    // Host-port strobes to the peripheral only when the pin is an input
    assign host_port_read_strobe_in = pin_dir[0] & digital_level[0];
    assign host_port_write_strobe_in = pin_dir[1] & digital_level[1];

    assign host_drive = {host_port_byte_enable, host_port_write_strobe, host_port_read_strobe};

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_oe[i] = ~pin_dir[i];
            pin_out[i] = host_port_enable ? host_drive[i] : latch_q[i];
            pin_pullup_en[i] = port_e_pullup_enable & pin_dir[i];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            latch_q <= LATCH_RESET;
        end else if (reg_wr && reg_addr == ADDR_LATCH) begin
            latch_q <= {5'h00, reg_wdata[2:0]};
        end else if (reg_wr && reg_addr == ADDR_PIN_LEVELS) begin
            // Writing the pin-level address lands in the latch
            latch_q <= {5'h00, reg_wdata[2:0]};
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dir_q <= DIR_RESET;
        end else if (reg_wr && reg_addr == ADDR_DIR) begin
            dir_q <= reg_wdata & DIR_WMASK;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            analog_q <= ANALOG_RESET;
        end else if (reg_wr && reg_addr == ADDR_ANALOG) begin
            analog_q <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            padcfg_q <= PADCFG_RESET;
        end else if (reg_wr && reg_addr == ADDR_PADCFG) begin
            padcfg_q <= {7'h00, reg_wdata[PADCFG_TTL_BIT]};
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_PIN_LEVELS: reg_rdata <= {5'h00, digital_level};
                ADDR_LATCH: reg_rdata <= latch_q;
                ADDR_DIR: reg_rdata <= dir_q;
                ADDR_ANALOG: reg_rdata <= analog_q;
                ADDR_PADCFG: reg_rdata <= padcfg_q;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    property p_reset_analog;
        @(posedge sys_clk) disable iff (!nrst)
        $rose(nrst) |-> analog_sel == 3'h7;
    endproperty
    a_reset_analog: assert property (p_reset_analog) else $error("pins not analog after reset");

    property p_analog_reads_zero;
        @(posedge sys_clk) disable iff (!nrst)
        (reg_rd && reg_addr == 3'h0 && analog_sel[0]) |=> reg_rdata[0] == 1'b0;
    endproperty
    a_analog_reads_zero: assert property (p_analog_reads_zero) else $error("analog pin read as digital");

    property p_output_from_latch;
        @(posedge sys_clk) disable iff (!nrst)
        (!pin_dir[2] && !host_port_enable) |-> (pin_oe[2] && pin_out[2] == latch_q[2]);
    endproperty
    a_output_from_latch: assert property (p_output_from_latch) else $error("output not from latch");

    property p_high_bits_zero;
        @(posedge sys_clk) disable iff (!nrst)
        (reg_rd && reg_addr[2:1] == 2'b00) |=> reg_rdata[7:3] == 5'h00;
    endproperty
    a_high_bits_zero: assert property (p_high_bits_zero) else $error("unimplemented bits nonzero");

    property p_latch_readback;
        @(posedge sys_clk) disable iff (!nrst)
        (reg_wr && reg_addr == 3'h1) ##1 (reg_rd && reg_addr == 3'h1) |=>
            reg_rdata[2:0] == $past(reg_wdata[2:0], 2);
    endproperty
    a_latch_readback: assert property (p_latch_readback) else $error("latch readback mismatch");

    property p_pullup_e;
        @(posedge sys_clk) disable iff (!nrst)
        (reg_wr && reg_addr == 3'h2 && reg_wdata[6] && reg_wdata[1]) |=> pin_pullup_en[1];
    endproperty
    a_pullup_e: assert property (p_pullup_e) else $error("port pull-up missing");

    property p_pullup_d;
        @(posedge sys_clk) disable iff (!nrst)
        (reg_wr && reg_addr == 3'h2) |=> port_d_pullup_enable == $past(reg_wdata[7]);
    endproperty
    a_pullup_d: assert property (p_pullup_d) else $error("neighbour pull-up wrong");

    property p_dir_input;
        @(posedge sys_clk) disable iff (!nrst)
        (reg_wr && reg_addr == 3'h2 && reg_wdata[0]) |=> !pin_oe[0];
    endproperty
    a_dir_input: assert property (p_dir_input) else $error("input pin driven");

    property p_ttl_select;
        @(posedge sys_clk) disable iff (!nrst)
        (reg_wr && reg_addr == 3'h4) |=> host_port_ttl_select == $past(reg_wdata[0]);
    endproperty
    a_ttl_select: assert property (p_ttl_select) else $error("ttl select not stored");

    property p_strobe_in;
        @(posedge sys_clk) disable iff (!nrst)
        !pin_dir[1] |-> !host_port_write_strobe_in;
    endproperty
    a_strobe_in: assert property (p_strobe_in) else $error("write strobe input while output");

    property p_read_strobe_in;
        @(posedge sys_clk) disable iff (!nrst)
        !pin_dir[0] |-> !host_port_read_strobe_in;
    endproperty
    a_read_strobe_in: assert property (p_read_strobe_in) else $error("read strobe input while output");

    property p_pin_read_levels;
        @(posedge sys_clk) disable iff (!nrst)
        (reg_rd && reg_addr == 3'h0) |=> reg_rdata[2:0] == $past(digital_level);
    endproperty
    a_pin_read_levels: assert property (p_pin_read_levels) else $error("pin read not pin level");

    property p_byte_enable_drive;
        @(posedge sys_clk) disable iff (!nrst)
        (host_port_enable && !pin_dir[2]) |-> (pin_oe[2] && pin_out[2] == host_port_byte_enable);
    endproperty
    a_byte_enable_drive: assert property (p_byte_enable_drive) else $error("byte enable not driven");

    property p_pullup_off;
        @(posedge sys_clk) disable iff (!nrst)
        !port_e_pullup_enable |-> pin_pullup_en == 3'h0;
    endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("pull-up on while disabled");

    property p_pullup_outputs;
        @(posedge sys_clk) disable iff (!nrst)
        (pin_pullup_en & ~pin_dir) == 3'h0;
    endproperty
    a_pullup_outputs: assert property (p_pullup_outputs) else $error("pull-up on driven pin");

    property p_read_idle_zero;
        @(posedge sys_clk) disable iff (!nrst)
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_read_idle_zero: assert property (p_read_idle_zero) else $error("read data outside read slot");

    property p_padcfg_high_zero;
        @(posedge sys_clk) disable iff (!nrst)
        (reg_rd && reg_addr == 3'h4) |=> reg_rdata[7:1] == 7'h00;
    endproperty
    a_padcfg_high_zero: assert property (p_padcfg_high_zero) else $error("pad config high bits set");

    property p_analog_sel_map;
        @(posedge sys_clk) disable iff (!nrst)
        (reg_wr && reg_addr == 3'h3) |=> pin_analog_sel == $past(reg_wdata[7:5]);
    endproperty
    a_analog_sel_map: assert property (p_analog_sel_map) else $error("analog select not mapped");
endmodule
`default_nettype wire

// file: verif/port_e_pads.sv
`timescale 1ns/1ps
`default_nettype none
module port_e_pads (
    input wire logic sys_clk,
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    input wire logic [2:0] pin_pullup_en,
    input wire logic [2:0] ext_drive,
    input wire logic ext_en,
    input wire logic [2:0] ttl_skew,
    output logic [2:0] pin_schmitt_in,
    output logic [2:0] pin_ttl_in
);
    logic [2:0] last_q;
    logic [2:0] pad;
    initial last_q = 3'h0;
    // Released pads with no pull-up wander instead of holding the last level
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pad[i] = pin_oe[i] ? pin_out[i] : ext_en ? ext_drive[i] : pin_pullup_en[i] ? 1'b1 : ~last_q[i];
        end
    end
    always @(posedge sys_clk) begin
        last_q <= pad;
    end
    assign pin_schmitt_in = pad;
    // Skewed bits mimic a level that only the TTL threshold reads differently
    assign pin_ttl_in = pad ^ ttl_skew;
endmodule
`default_nettype wire

// file: verif/port_e_pin_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module port_e_pin_control_test;
    import port_e_pkg::*;
    logic sys_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, hp_en = 0, hp_rd = 0, hp_wr = 0, hp_be = 0, ext_en = 0;
    logic [2:0] reg_addr = 3'h0, ext_drive = 3'h0, ttl_skew = 3'h0, sch, ttl, p_out, p_oe, p_pu, p_an;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic rd_in, wr_in, d_pu, ttl_sel;
    int bad_count = 0, num_checks = 0;
    always #5 sys_clk = ~sys_clk;
    port_e_pin_control dut_u (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_schmitt_in(sch), .pin_ttl_in(ttl),
        .pin_out(p_out), .pin_oe(p_oe), .pin_pullup_en(p_pu), .pin_analog_sel(p_an), .host_port_enable(hp_en),
        .host_port_read_strobe(hp_rd), .host_port_write_strobe(hp_wr), .host_port_byte_enable(hp_be),
        .host_port_read_strobe_in(rd_in), .host_port_write_strobe_in(wr_in), .port_d_pullup_enable(d_pu),
        .host_port_ttl_select(ttl_sel));
    port_e_pads pads_u (.sys_clk(sys_clk), .pin_out(p_out), .pin_oe(p_oe), .pin_pullup_en(p_pu),
        .ext_drive(ext_drive), .ext_en(ext_en), .ttl_skew(ttl_skew), .pin_schmitt_in(sch), .pin_ttl_in(ttl));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input string what, input logic [2:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(what, exp, reg_rdata);
    endtask
    task automatic settle();
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    task automatic reset_state();
        chk("oe", 8'h00, {5'h0, p_oe});
        chk("analog", 8'h07, {5'h0, p_an});
        chk("ttl_sel", 8'h00, {7'h0, ttl_sel});
        rd("dir", ADDR_DIR, 8'h07);
        rd("ancfg", ADDR_ANALOG, 8'hff);
        rd("latch", ADDR_LATCH, 8'h00);
        rd("pins_analog", ADDR_PIN_LEVELS, 8'h00);
    endtask
    task automatic latch_drive();
        wr(ADDR_LATCH, 8'hfd);
        rd("latch_rb", ADDR_LATCH, 8'h05);
        wr(ADDR_DIR, 8'h00);
        #1 chk("drive_analog", 8'h05, {5'h0, p_out & p_oe});
        rd("pins_an", ADDR_PIN_LEVELS, 8'h00);
        wr(ADDR_ANALOG, 8'h1f);
        settle();
        chk("an_sel", 8'h00, {5'h0, p_an});
        rd("pins_dig", ADDR_PIN_LEVELS, 8'h05);
        wr(ADDR_ANALOG, 8'h9f);
        rd("pin2_an", ADDR_PIN_LEVELS, 8'h01);
        wr(ADDR_ANALOG, 8'h3f);
        rd("pin0_an", ADDR_PIN_LEVELS, 8'h04);
        wr(ADDR_ANALOG, 8'h00);
    endtask
    task automatic back_to_back();
        @(posedge sys_clk);
        reg_addr <= ADDR_LATCH;
        reg_wdata <= 8'h02;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk("wr_rd_b2b", 8'h02, reg_rdata);
    endtask
    task automatic pullups();
        wr(ADDR_DIR, 8'hff);
        rd("dir_mask", ADDR_DIR, 8'hc7);
        settle();
        chk("pu", 8'h07, {5'h0, p_pu});
        chk("d_pu", 8'h01, {7'h0, d_pu});
        rd("pins_pu", ADDR_PIN_LEVELS, 8'h07);
        wr(ADDR_DIR, 8'h43);
        #1 chk("pu_in_only", 8'h03, {5'h0, p_pu});
        chk("d_pu_off", 8'h00, {7'h0, d_pu});
        wr(ADDR_DIR, 8'h83);
        #1 chk("pu_off", 8'h00, {5'h0, p_pu});
        chk("d_pu_on", 8'h01, {7'h0, d_pu});
        rd("unmapped", 3'h5, 8'h00);
    endtask
    task automatic host_port();
        hp_en <= 1'b1;
        hp_rd <= 1'b1;
        hp_be <= 1'b1;
        wr(ADDR_DIR, 8'h00);
        #1 chk("strobes_out", 8'h05, {5'h0, p_out});
        @(posedge sys_clk);
        hp_rd <= 1'b0;
        hp_wr <= 1'b1;
        @(posedge sys_clk);
        #1 chk("wr_strobe_out", 8'h06, {5'h0, p_out});
        ext_en <= 1'b1;
        ext_drive <= 3'h3;
        ttl_skew <= 3'h2;
        wr(ADDR_DIR, 8'h07);
        settle();
        chk("schmitt_in", 8'h03, {6'h0, wr_in, rd_in});
        wr(ADDR_PADCFG, 8'h01);
        settle();
        chk("ttl_sel_on", 8'h01, {7'h0, ttl_sel});
        chk("ttl_in", 8'h01, {6'h0, wr_in, rd_in});
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        #1 reset_state();
        latch_drive();
        back_to_back();
        pullups();
        host_port();
        print_verdict();
    end
    initial begin
        #20000;
        bad_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
